// ===== irq_ctrl_consts.svh
// Constants of the interrupt flag group controller
// Assumes inclusion by bare name from the package and the design files
`ifndef IRQ_CTRL_CONSTS_SVH
`define IRQ_CTRL_CONSTS_SVH

// Vector number width and numbering
`define IRQ_VEC_W        8
`define SWSEL_VEC_BASE   8'h80
`define SWSEL_VEC_LAST   8'hff

// Group slots inside the ordinary source vector
`define GRP_NUM          7
`define GRP_SYS_EDGE     0
`define GRP_PER_EDGE     1
`define GRP_LVL_FIRST    2
`define GRP_LVL_NUM      5

// Filter: matching samples needed and prescaler width
`define FILT_MATCH       3
`define FILT_PRE_W       6
`define FILT_DIV_8       6'h07
`define FILT_DIV_32      6'h1f
`define FILT_DIV_64      6'h3f

// Reset values
`define CPU_IE_RST       1'b0

`endif

// ===== irq_ctrl_pkg.sv
// Types shared by the interrupt flag group controller
// Assumes irq_ctrl_consts.svh is on the include path
`include "irq_ctrl_consts.svh"

package irq_ctrl_pkg;

  // Request towards the processor core
  typedef struct packed {
    logic                  req;
    logic                  fast;
    logic [`IRQ_VEC_W-1:0] vec;
  } irq_out_t;

  // Request towards the transfer controllers
  typedef struct packed {
    logic                  req;
    logic [`IRQ_VEC_W-1:0] vec;
  } xfer_out_t;

  typedef enum logic [1:0] {
    DIV_1,
    DIV_8,
    DIV_32,
    DIV_64
  } filt_div_t;

endpackage

// ===== pin_noise_filter.sv
// Digital noise filter for one synchronised pin level
// Assumes the input already passed a two-stage synchroniser
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_consts.svh"

module pin_noise_filter (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic RST,
  // Sample strobe and pin
  input  wire logic sample_tick,
  input  wire logic pin_sync,
  // Filtered level
  output logic      level_q
);

  logic [`FILT_MATCH-2:0] hist_q;
  wire                    all_high = pin_sync & (&hist_q);
  wire                    all_low  = ~pin_sync & ~(|hist_q);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      hist_q  <= '0;
      level_q <= 1'b0;
    end else if (sample_tick) begin
      hist_q <= {hist_q[`FILT_MATCH-3:0], pin_sync};
      if (all_high) begin
        level_q <= 1'b1;
      end else if (all_low) begin
        level_q <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ===== irq_flag_ctrl.sv
// Interrupt flag group controller: flags, routing, groups, selectable interrupts
// Assumes sources and acks come from logic on CLK; pins are asynchronous
//
// Function
// - Edge source flag clears itself when its acceptance is acknowledged.
// - Level source acceptance clears own flag; for peripheral sources it also pulses the peripheral flag clear.
// - Flags held here; pending source goes to core or transfer controllers.
// - Fast source wins priority; acceptance copies control register into backup.
// - Pin and non-maskable inputs filtered; pulses under three samples rejected.
// - Accepting an interrupt clears the core interrupt-enable bit.
// - Setting the enable bit again lets a higher request preempt.
// - Group request is the OR of its member requests.
// - Groups: system edge, peripheral B edge, three level, two fast-clock level.
// - Edge group status bit clears on a written one to its clear bit.
// - Level group status bit follows the peripheral flag.
// - Level group status bit clears when its enable is zero.
// - Each selectable interrupt routes one chosen source to its own SEL_FLAG and SEL_PULSE bits.
// - Two selectable classes, for peripheral clock A and B sources.
// - Selectable flags never self-clear and never block later requests.
// - Per-source selection decides transfer controller activation.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_consts.svh"

module irq_flag_ctrl #(
  parameter  int N_SRC = 16,
  parameter  int N_EXT = 8,
  parameter  int GW    = 8,
  parameter  int SEL_N = 4,
  parameter  int SEL_M = 16,
  parameter  int DW    = 32,
  localparam int NT    = N_SRC + N_EXT + `GRP_NUM,
  localparam int IW    = $clog2(NT),
  localparam int SW    = $clog2(SEL_M)
) (
  // Clock and reset
  input  wire logic                          CLK,
  input  wire logic                          RST,
  // Peripheral sources
  input  wire logic [N_SRC-1:0]              SRC_REQ,
  input  wire logic [N_SRC-1:0]              SRC_LEVEL,
  input  wire logic [NT-1:0]                 SRC_ENABLE,
  input  wire logic [NT-1:0]                 SRC_TO_XFER,
  output logic      [N_SRC-1:0]              PERIPH_CLR,
  // Fast interrupt selection
  input  wire logic                          FAST_EN,
  input  wire logic [IW-1:0]                 FAST_IDX,
  // Pins and filter
  input  wire logic [N_EXT-1:0]              EXT_PIN,
  input  wire logic                          NMI_PIN,
  input  wire irq_ctrl_pkg::filt_div_t       FILT_DIV,
  input  wire logic                          NMI_ACK,
  output logic                               NMI_REQ,
  // Group interrupts
  input  wire logic [GW-1:0]                 SYS_EDGE_IN,
  input  wire logic [GW-1:0]                 SYS_EDGE_CLR,
  input  wire logic [GW-1:0]                 PER_EDGE_IN,
  input  wire logic [GW-1:0]                 PER_EDGE_CLR,
  input  wire logic [`GRP_LVL_NUM-1:0][GW-1:0] LVL_IN,
  input  wire logic [`GRP_LVL_NUM-1:0][GW-1:0] LVL_EN,
  output logic      [`GRP_NUM-1:0][GW-1:0]   GRP_STATUS,
  // Selectable interrupts, class 0 on clock A, class 1 on clock B
  input  wire logic [1:0][SEL_M-1:0]         SEL_SRC,
  input  wire logic [1:0][SEL_N-1:0][SW-1:0] SEL_IDX,
  input  wire logic [1:0][SEL_N-1:0]         SEL_CLR,
  output logic      [1:0][SEL_N-1:0]         SEL_FLAG,
  output logic      [1:0][SEL_N-1:0]         SEL_PULSE,
  // Processor core
  input  wire logic                          CPU_ACK,
  input  wire logic                          CPU_IE_SET,
  input  wire logic [DW-1:0]                 CPU_CTRL,
  output irq_ctrl_pkg::irq_out_t             IRQ,
  output logic                               CPU_IE,
  output logic      [DW-1:0]                 FAST_BACKUP,
  // Transfer controllers
  input  wire logic                          XFER_ACK,
  output irq_ctrl_pkg::xfer_out_t            XFER
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and filters

  logic [N_EXT:0]          meta_q;
  logic [N_EXT:0]          sync_q;
  logic [N_EXT:0]          filt_lvl;
  logic [N_EXT:0]          filt_prev_q;
  logic [`FILT_PRE_W-1:0]  pre_q;
  logic                    tick;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      meta_q <= '0;
      sync_q <= '0;
      pre_q  <= '0;
    end else begin
      meta_q <= {NMI_PIN, EXT_PIN};
      sync_q <= meta_q;
      pre_q  <= pre_q + `FILT_PRE_W'(1);
    end
  end

  assign tick = (FILT_DIV == irq_ctrl_pkg::DIV_1)  ? 1'b1 :
                (FILT_DIV == irq_ctrl_pkg::DIV_8)  ? ((pre_q & `FILT_DIV_8) == '0) :
                (FILT_DIV == irq_ctrl_pkg::DIV_32) ? ((pre_q & `FILT_DIV_32) == '0) :
                                                     ((pre_q & `FILT_DIV_64) == '0);

  for (genvar p = 0; p <= N_EXT; p++) begin : g_filt
    pin_noise_filter u_filt (
      .CLK         (CLK),
      .RST         (RST),
      .sample_tick (tick),
      .pin_sync    (sync_q[p]),
      .level_q     (filt_lvl[p])
    );
  end

  wire [N_EXT:0] filt_rise = filt_lvl & ~filt_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Group interrupts

  logic [GW-1:0] sys_prev_q;
  logic [GW-1:0] per_prev_q;
  logic [GW-1:0] sys_st_q;
  logic [GW-1:0] per_st_q;
  logic [`GRP_NUM-1:0] grp_req;

  wire [GW-1:0] sys_st_d = (SYS_EDGE_IN & ~sys_prev_q) | (sys_st_q & ~SYS_EDGE_CLR);
  wire [GW-1:0] per_st_d = (PER_EDGE_IN & ~per_prev_q) | (per_st_q & ~PER_EDGE_CLR);

  assign grp_req[`GRP_SYS_EDGE] = |sys_st_q;
  assign grp_req[`GRP_PER_EDGE] = |per_st_q;
  for (genvar g = 0; g < `GRP_LVL_NUM; g++) begin : g_lvl
    assign grp_req[`GRP_LVL_FIRST+g] = |(LVL_IN[g] & LVL_EN[g]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source flags

  wire [NT-1:0] req_all   = {grp_req, filt_rise[N_EXT-1:0], SRC_REQ};
  wire [NT-1:0] level_all = {{`GRP_NUM{1'b1}}, {N_EXT{1'b0}}, SRC_LEVEL};
  logic [NT-1:0] prev_q;
  logic [NT-1:0] hold_q;
  logic [NT-1:0] flag_q;
  logic [NT-1:0] ack_mask;

  wire cpu_take  = CPU_ACK & IRQ.req;
  wire xfer_take = XFER_ACK & XFER.req;

  always_comb begin
    ack_mask = '0;
    if (cpu_take) begin
      ack_mask[IRQ.vec[IW-1:0]] = 1'b1;
    end
    if (xfer_take) begin
      ack_mask[XFER.vec[IW-1:0]] = 1'b1;
    end
  end

  // Level sources stay blocked until the peripheral drops its request
  wire [NT-1:0] hold_d = level_all & (ack_mask | (hold_q & req_all));
  // edge flag cleared by acceptance, new edge wins
  wire [NT-1:0] flag_d = (level_all & req_all & ~hold_d) |
                         (~level_all & ((req_all & ~prev_q) | (flag_q & ~ack_mask)));

  wire [NT-1:0] pend = flag_q & SRC_ENABLE & ~ack_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Priority selection

  logic [IW-1:0] cpu_sel;
  logic          cpu_any;
  logic [IW-1:0] xfer_sel;
  logic          xfer_any;

  // lowest index wins within each destination
  always_comb begin
    cpu_sel  = '0;
    cpu_any  = 1'b0;
    xfer_sel = '0;
    xfer_any = 1'b0;
    for (int i = NT - 1; i >= 0; i--) begin
      if (pend[i] && !SRC_TO_XFER[i]) begin
        cpu_sel = IW'(i);
        cpu_any = 1'b1;
      end
      if (pend[i] && SRC_TO_XFER[i]) begin
        xfer_sel = IW'(i);
        xfer_any = 1'b1;
      end
    end
  end

  wire           fast_hit = FAST_EN && pend[FAST_IDX] && !SRC_TO_XFER[FAST_IDX];
  wire [IW-1:0]  cpu_pick = fast_hit ? FAST_IDX : cpu_sel;
  wire           ie_d     = CPU_IE_SET | (CPU_IE & ~cpu_take);
  wire           cpu_go   = (cpu_any | fast_hit) & ie_d;

  ////////////////////////////////////////////////////////////////////////////
  // Selectable interrupts

  logic [1:0][SEL_N-1:0] sel_lvl;
  logic [1:0][SEL_N-1:0] sel_prev_q;

  for (genvar c = 0; c < 2; c++) begin : g_cls
    for (genvar k = 0; k < SEL_N; k++) begin : g_slot
      assign sel_lvl[c][k] = SEL_SRC[c][SEL_IDX[c][k]];
    end
  end

  wire [1:0][SEL_N-1:0] sel_rise = sel_lvl & ~sel_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      filt_prev_q <= '0;
      sys_prev_q  <= '0;
      per_prev_q  <= '0;
      sys_st_q    <= '0;
      per_st_q    <= '0;
      GRP_STATUS  <= '0;
      prev_q      <= '0;
      hold_q      <= '0;
      flag_q      <= '0;
      sel_prev_q  <= '0;
      SEL_FLAG    <= '0;
      SEL_PULSE   <= '0;
      NMI_REQ     <= 1'b0;
      CPU_IE      <= `CPU_IE_RST;
      IRQ         <= '0;
      XFER        <= '0;
      FAST_BACKUP <= '0;
      PERIPH_CLR  <= '0;
    end else begin
      filt_prev_q <= filt_lvl;
      sys_prev_q  <= SYS_EDGE_IN;
      per_prev_q  <= PER_EDGE_IN;
      sys_st_q    <= sys_st_d;
      per_st_q    <= per_st_d;
      GRP_STATUS  <= {LVL_IN & LVL_EN, per_st_d, sys_st_d};
      prev_q      <= req_all;
      hold_q      <= hold_d;
      flag_q      <= flag_d;
      sel_prev_q  <= sel_lvl;
      SEL_FLAG    <= sel_rise | (SEL_FLAG & ~SEL_CLR);
      SEL_PULSE   <= sel_rise;
      NMI_REQ     <= filt_rise[N_EXT] | (NMI_REQ & ~NMI_ACK);
      CPU_IE      <= ie_d;
      IRQ.req     <= cpu_go;
      IRQ.fast    <= cpu_go & fast_hit;
      IRQ.vec     <= `IRQ_VEC_W'(cpu_pick);
      XFER.req    <= xfer_any;
      XFER.vec    <= `IRQ_VEC_W'(xfer_sel);
      if (cpu_take && IRQ.fast) begin
        FAST_BACKUP <= CPU_CTRL;
      end
      PERIPH_CLR  <= ack_mask[N_SRC-1:0] & SRC_LEVEL;
    end
  end

endmodule
`default_nettype wire

// ===== periph_model.sv
// Peripheral model holding a level request flag
// Assumes raise and clear are pulses on the controller clock
`timescale 1ns/1ps
`default_nettype none
module periph_model (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic RST,
  // Control and request
  input  wire logic raise,
  input  wire logic clr,
  output var  logic req
);
  always_ff @(posedge CLK or posedge RST) begin
    if (RST)
      req <= 1'h0;
    else if (clr)
      req <= 1'h0;
    else if (raise)
      req <= 1'h1;
  end
endmodule
`default_nettype wire

// ===== irq_flag_ctrl_properties.sv
// Assertions on the controller top module ports
// Assumes one clock, reset active high
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_consts.svh"
module irq_flag_ctrl_props #(
  parameter  int N_SRC = 16,
  parameter  int GW    = 8,
  parameter  int SEL_M = 16,
  parameter  int SEL_N = 4,
  parameter  int DW    = 32,
  localparam int SW    = $clog2(SEL_M)
) (
  // Clock, reset and core
  input wire logic CLK, RST, CPU_ACK, CPU_IE_SET, CPU_IE, XFER_ACK, NMI_REQ,
  input wire logic [DW-1:0] CPU_CTRL, FAST_BACKUP,
  input wire irq_ctrl_pkg::irq_out_t IRQ,
  input wire irq_ctrl_pkg::xfer_out_t XFER,
  // Sources and groups
  input wire logic [N_SRC-1:0] SRC_LEVEL, PERIPH_CLR,
  input wire logic [GW-1:0] SYS_EDGE_IN, SYS_EDGE_CLR,
  input wire logic [`GRP_LVL_NUM-1:0][GW-1:0] LVL_IN, LVL_EN,
  input wire logic [`GRP_NUM-1:0][GW-1:0] GRP_STATUS,
  // Selectable interrupts
  input wire logic [1:0][SEL_M-1:0] SEL_SRC,
  input wire logic [1:0][SEL_N-1:0][SW-1:0] SEL_IDX,
  input wire logic [1:0][SEL_N-1:0] SEL_CLR, SEL_FLAG, SEL_PULSE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  wire logic s0;
  assign s0 = SEL_SRC[0][SEL_IDX[0][1]];
  property p_ie_clr; CPU_ACK && IRQ.req && !CPU_IE_SET |=> !CPU_IE; endproperty
  a_ie_clr: assert property (p_ie_clr) else $error("enable kept");
  property p_ie_set; CPU_IE_SET |=> CPU_IE; endproperty
  a_ie_set: assert property (p_ie_set) else $error("enable not set");
  property p_bak; CPU_ACK && IRQ.req && IRQ.fast |=> FAST_BACKUP == $past(CPU_CTRL); endproperty
  a_bak: assert property (p_bak) else $error("backup wrong");
  property p_pclr; CPU_ACK && IRQ.req && IRQ.vec == 8'h02 && SRC_LEVEL[2] |=> PERIPH_CLR[2]; endproperty
  a_pclr: assert property (p_pclr) else $error("no peripheral clear");
  property p_xone; XFER_ACK && XFER.req |=> !(XFER.req && XFER.vec == $past(XFER.vec)); endproperty
  a_xone: assert property (p_xone) else $error("flag not cleared");
  property p_eclr;
    GRP_STATUS[0][1] && SYS_EDGE_CLR[1] && SYS_EDGE_IN[1] && $past(SYS_EDGE_IN[1])
      |=> !GRP_STATUS[0][1];
  endproperty
  a_eclr: assert property (p_eclr) else $error("edge status kept");
  property p_lvl; 1 |=> GRP_STATUS[2] == $past(LVL_IN[0] & LVL_EN[0]); endproperty
  a_lvl: assert property (p_lvl) else $error("level status wrong");
  property p_sel; $rose(s0) |-> ##[1:2] SEL_PULSE[0][1]; endproperty
  a_sel: assert property (p_sel) else $error("no selectable pulse");
  property p_flag; SEL_FLAG[1][1] && !SEL_CLR[1][1] |=> SEL_FLAG[1][1]; endproperty
  a_flag: assert property (p_flag) else $error("flag self cleared");
  c_fast: cover property (CPU_ACK && IRQ.req && IRQ.fast);
  c_xfer: cover property (XFER_ACK && XFER.req);
  c_nmi: cover property ($rose(NMI_REQ));
endmodule
bind irq_flag_ctrl irq_flag_ctrl_props #(.N_SRC(N_SRC), .GW(GW), .SEL_M(SEL_M), .SEL_N(SEL_N),
  .DW(DW)) props_u (.*);
`default_nettype wire

// ===== tb_top.sv
// Testbench of the interrupt flag group controller
// Assumes design, peripheral model and checker compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_consts.svh"
module tb_top;
  localparam int NS = 4, NE = 2, GW = 2, SN = 2, SM = 4, DW = 8, NT = NS + NE + `GRP_NUM;
  logic clk, rst, ie_set, ack, xack, nmi_pin, nmi_ack, fast_en, raise, nmi_req, cpu_ie, lreq;
  logic [NS-1:0] sreq, slvl, pclr;
  logic [NT-1:0] sen, sxfer;
  logic [3:0] fidx;
  logic [NE-1:0] ext;
  logic [GW-1:0] sys_in, sys_clr, per_in, per_clr;
  logic [`GRP_LVL_NUM-1:0][GW-1:0] lvl_in, lvl_en;
  logic [`GRP_NUM-1:0][GW-1:0] gst;
  logic [1:0][SM-1:0] sel_src;
  logic [1:0][SN-1:0][1:0] sel_idx;
  logic [1:0][SN-1:0] sel_clr, sel_flag, sel_pulse;
  logic [DW-1:0] ctrl, backup;
  irq_ctrl_pkg::filt_div_t fdiv;
  irq_ctrl_pkg::irq_out_t irq;
  irq_ctrl_pkg::xfer_out_t xfer;
  int miscompares, checked, n;
  irq_flag_ctrl #(.N_SRC(NS), .N_EXT(NE), .GW(GW), .SEL_N(SN), .SEL_M(SM), .DW(DW)) dut_u (
    .CLK(clk), .RST(rst), .SRC_REQ(sreq | {1'h0, lreq, 2'h0}), .SRC_LEVEL(slvl),
    .SRC_ENABLE(sen), .SRC_TO_XFER(sxfer), .PERIPH_CLR(pclr), .FAST_EN(fast_en),
    .FAST_IDX(fidx), .EXT_PIN(ext), .NMI_PIN(nmi_pin), .FILT_DIV(fdiv), .NMI_ACK(nmi_ack),
    .NMI_REQ(nmi_req), .SYS_EDGE_IN(sys_in), .SYS_EDGE_CLR(sys_clr), .PER_EDGE_IN(per_in),
    .PER_EDGE_CLR(per_clr), .LVL_IN(lvl_in), .LVL_EN(lvl_en), .GRP_STATUS(gst),
    .SEL_SRC(sel_src), .SEL_IDX(sel_idx), .SEL_CLR(sel_clr), .SEL_FLAG(sel_flag),
    .SEL_PULSE(sel_pulse), .CPU_ACK(ack), .CPU_IE_SET(ie_set), .CPU_CTRL(ctrl), .IRQ(irq),
    .CPU_IE(cpu_ie), .FAST_BACKUP(backup), .XFER_ACK(xack), .XFER(xfer));
  periph_model pm_u (.CLK(clk), .RST(rst), .raise(raise), .clr(pclr[2]), .req(lreq));
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  task automatic step(input int k = 1);
    repeat (k) @(negedge clk);
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic set_ie;
    ie_set = 1'h1;
    step();
    ie_set = 1'h0;
  endtask
  task automatic take(input logic x);
    if (x) xack = 1'h1;
    else ack = 1'h1;
    step();
    {xack, ack} = 2'h0;
  endtask
  task automatic t_edge;
    set_ie();
    sreq[1] = 1'h1;
    for (n = 0; n < 30 && irq.req !== 1'h1; n++) step();
    chk(irq, 16'h0201);
    take(1'h0);
    chk(cpu_ie, 16'h0);
    set_ie();
    step(2);
    chk(irq.req, 16'h0);
    $display("edge test done");
  endtask
  task automatic t_fast;
    {fast_en, fidx, slvl[2], ctrl} = {1'h1, 4'h2, 1'h1, 8'ha5};
    raise = 1'h1;
    step();
    {sreq[0], raise} = 2'h2;
    for (n = 0; n < 30 && irq.req !== 1'h1; n++) step();
    chk(irq, 16'h0302);
    take(1'h0);
    chk(backup, 16'h00a5);
    step(3);
    chk(lreq, 16'h0);
    set_ie();
    for (n = 0; n < 30 && irq.req !== 1'h1; n++) step();
    chk(irq, 16'h0200);
    take(1'h0);
    $display("fast test done");
  endtask
  task automatic t_grp;
    int g;
    {sxfer[3], sxfer[6], sreq[3]} = 3'h7;
    for (n = 0; n < 30 && xfer.req !== 1'h1; n++) step();
    chk(xfer, 16'h0103);
    take(1'h1);
    sys_in[1] = 1'h1;
    for (n = 0; n < 30 && xfer.req !== 1'h1; n++) step();
    chk(xfer, 16'h0106);
    chk(gst[0], 16'h2);
    take(1'h1);
    sys_clr[1] = 1'h1;
    step();
    sys_clr[1] = 1'h0;
    step(2);
    chk(gst[0], 16'h0);
    for (g = 0; g < 5; g += 4) begin
      {lvl_in[g][1], lvl_en[g][1]} = 2'h3;
      step(2);
      chk(gst[g+2], 16'h2);
      lvl_in[g][1] = 1'h0;
      step(2);
      chk(gst[g+2], 16'h0);
      lvl_in[g][1] = 1'h1;
      step(2);
      chk(gst[g+2], 16'h2);
      lvl_en[g][1] = 1'h0;
      step(2);
      chk(gst[g+2], 16'h0);
      lvl_in[g][1] = 1'h0;
    end
    $display("group test done");
  endtask
  task automatic t_sel;
    int c, k, hits;
    for (c = 0; c < 2; c++) begin
      for (k = 0; k < 2; k++) begin
        hits = 0;
        sel_src[c][c+1] = 1'h1;
        repeat (4) begin
          step();
          hits += int'(sel_pulse[c][1]);
        end
        sel_src[c][c+1] = 1'h0;
        step();
        chk(16'(hits), 16'h1);
      end
      chk(sel_flag[c], 16'h2);
      sel_clr[c][1] = 1'h1;
      step();
      sel_clr[c][1] = 1'h0;
      step(2);
      chk(sel_flag[c], 16'h0);
    end
    $display("selectable test done");
  endtask
  task automatic t_nmi;
    int d;
    for (d = 0; d < 2; d++) begin
      fdiv = d ? irq_ctrl_pkg::DIV_8 : irq_ctrl_pkg::DIV_1;
      nmi_pin = 1'h1;
      step(d ? 10 : 2);
      nmi_pin = 1'h0;
      step(40);
      chk(nmi_req, 16'h0);
      nmi_pin = 1'h1;
      step(d ? 40 : 6);
      nmi_pin = 1'h0;
      step(40);
      chk(nmi_req, 16'h1);
      nmi_ack = 1'h1;
      step();
      nmi_ack = 1'h0;
      step();
    end
    $display("filter test done");
  endtask
  task automatic end_sim;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {ie_set, ack, xack, nmi_pin, nmi_ack, fast_en, raise, sreq, slvl, sxfer, fidx} = '0;
    {ext, sys_in, sys_clr, per_in, per_clr, lvl_in, lvl_en, sel_src, sel_clr, ctrl} = '0;
    {sen, sel_idx, fdiv} = {{NT{1'h1}}, 8'h84, irq_ctrl_pkg::DIV_1};
    rst = 1'h1;
    step(8);
    rst = 1'h0;
    t_edge();
    t_fast();
    t_grp();
    t_sel();
    t_nmi();
    end_sim();
  end
  initial begin
    #20000;
    miscompares++;
    end_sim();
  end
endmodule
`default_nettype wire
